// [rtl/cpusr_pkg.sv]
// package for the cpu register side: status bits, constants, mode codes
// assumes nothing beyond a systemverilog compiler
package cpusr_pkg;
  localparam int DATA_W = 16;
  localparam int REG_CNT = 16;
  // register indices with dedicated roles
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_CONST = 4'h3;
  // status bit positions
  localparam int BIT_C = 0;
  localparam int BIT_Z = 1;
  localparam int BIT_N = 2;
  localparam int BIT_GIE = 3;
  localparam int BIT_HALT = 4;
  localparam int BIT_LOWFREQ_CRYSTAL_STOP = 5;
  localparam int BIT_CG0 = 6;
  localparam int BIT_CG1 = 7;
  localparam int BIT_V = 8;
  localparam logic [15:0] STATUS_MASK = 16'h01ff;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] REG_RST = 16'h0000;
  // generated constants
  localparam logic [15:0] CONST_ZERO = 16'h0000;
  localparam logic [15:0] CONST_ONE = 16'h0001;
  localparam logic [15:0] CONST_TWO = 16'h0002;
  localparam logic [15:0] CONST_FOUR = 16'h0004;
  localparam logic [15:0] CONST_EIGHT = 16'h0008;
  localparam logic [15:0] CONST_ONES = 16'hffff;
  localparam logic [15:0] INC_BYTE = 16'h0001;
  localparam logic [15:0] INC_WORD = 16'h0002;
  // source mode field codes
  localparam logic [1:0] AS_REG = 2'h0;
  localparam logic [1:0] AS_IDX = 2'h1;
  localparam logic [1:0] AS_IND = 2'h2;
  localparam logic [1:0] AS_INC = 2'h3;
  // alu operation classes relevant to the flags
  typedef enum logic [2:0] {
    CPUSR_OP_MOV = 3'b000,
    CPUSR_OP_ADD = 3'b001,
    CPUSR_OP_ADDC = 3'b010,
    CPUSR_OP_SUB = 3'b011,
    CPUSR_OP_SUBC = 3'b100,
    CPUSR_OP_CMP = 3'b101,
    CPUSR_OP_LOGIC = 3'b110
  } cpusr_op_t;
  // decoded operand access kinds
  typedef enum logic [2:0] {
    CPUSR_ACC_REG = 3'b000,
    CPUSR_ACC_INDEXED = 3'b001,
    CPUSR_ACC_SYMBOLIC = 3'b010,
    CPUSR_ACC_ABSOLUTE = 3'b011,
    CPUSR_ACC_INDIRECT = 3'b100,
    CPUSR_ACC_AUTOINC = 3'b101,
    CPUSR_ACC_IMMEDIATE = 3'b110,
    CPUSR_ACC_CONST = 3'b111
  } cpusr_acc_t;
endpackage

// [rtl/cpusr_mode_dec.sv]
// source and destination addressing-mode decoder with constant generator
// assumes register numbers and mode fields come from the sequencer
`timescale 1ns/10ps
module cpusr_mode_dec
  import cpusr_pkg::*;
(
  input wire logic [3:0] src_reg,
  input wire logic [1:0] source_mode_field,
  input wire logic byte_op,
  input wire logic [3:0] dst_reg,
  input wire logic dst_mode,
  output cpusr_acc_t src_acc,
  output cpusr_acc_t dst_acc,
  output logic [15:0] const_val,
  output logic src_ext_word,
  output logic dst_ext_word,
  output logic [15:0] src_inc
);
  // status register is a plain operand only in word register mode
  wire logic sr_plain = (source_mode_field == AS_REG) && !byte_op; // RQ2
  wire logic is_sr = (src_reg == REG_STATUS);
  wire logic is_r3 = (src_reg == REG_CONST);
  // const_source_a is r2 (except abs and word register modes), const_source_b is r3
  wire logic cg_a = is_sr && !sr_plain &&
                    (source_mode_field != AS_IDX); // RQ2 RQ13
  wire logic cg_b = is_r3; // RQ14
  wire logic is_const = cg_a || cg_b;

  // constant table for both generators
  always_comb begin
    const_val = CONST_ZERO;
    if (is_r3) begin
      case (source_mode_field)
        AS_REG: const_val = CONST_ZERO; // RQ14
        AS_IDX: const_val = CONST_ONE; // RQ14
        AS_IND: const_val = CONST_TWO; // RQ14
        default: const_val = CONST_ONES; // RQ14
      endcase
    end else if (is_sr) begin
      case (source_mode_field)
        AS_IND: const_val = CONST_FOUR; // RQ13
        AS_INC: const_val = CONST_EIGHT; // RQ13
        default: const_val = CONST_ZERO; // RQ13
      endcase
    end
  end

  // source access kind: seven modes from the two-bit field
  always_comb begin
    src_acc = CPUSR_ACC_REG; // RQ18
    if (is_const) begin
      src_acc = CPUSR_ACC_CONST;
    end else begin
      case (source_mode_field)
        AS_REG: src_acc = CPUSR_ACC_REG;
        AS_IDX: begin
          if (src_reg == REG_PC) src_acc = CPUSR_ACC_SYMBOLIC; // RQ20
          else if (is_sr) src_acc = CPUSR_ACC_ABSOLUTE; // RQ21
          else src_acc = CPUSR_ACC_INDEXED; // RQ19
        end
        AS_IND: src_acc = CPUSR_ACC_INDIRECT; // RQ22
        default: begin
          if (src_reg == REG_PC) src_acc = CPUSR_ACC_IMMEDIATE; // RQ24
          else src_acc = CPUSR_ACC_AUTOINC; // RQ23
        end
      endcase
    end
  end

  // destination: register or indexed family only
  always_comb begin
    dst_acc = CPUSR_ACC_REG;
    if (dst_mode) begin
      if (dst_reg == REG_PC) dst_acc = CPUSR_ACC_SYMBOLIC; // RQ20
      else if (dst_reg == REG_STATUS) dst_acc = CPUSR_ACC_ABSOLUTE; // RQ21
      else dst_acc = CPUSR_ACC_INDEXED; // RQ19
    end
  end

  // extension words: indexed family and immediate, never constants
  assign src_ext_word = (src_acc == CPUSR_ACC_INDEXED) ||
                        (src_acc == CPUSR_ACC_SYMBOLIC) ||
                        (src_acc == CPUSR_ACC_ABSOLUTE) ||
                        (src_acc == CPUSR_ACC_IMMEDIATE); // RQ14
  assign dst_ext_word = dst_mode; // RQ19
  // post-increment size, byte 1 or word 2 (pc always steps a word)
  assign src_inc = (byte_op && src_reg != REG_PC) ?
                   INC_BYTE : INC_WORD; // RQ23 RQ24
endmodule

// [rtl/cpusr_flag_calc.sv]
// flag computation for byte and word results
// assumes operands and result are presented in the same cycle
`timescale 1ns/10ps
module cpusr_flag_calc
  import cpusr_pkg::*;
(
  input cpusr_op_t op,
  input wire logic byte_op,
  input wire logic [15:0] src_val,
  input wire logic [15:0] dst_val,
  input wire logic carry_in,
  output logic [15:0] result,
  output logic flag_v,
  output logic flag_n,
  output logic flag_z,
  output logic flag_c
);
  logic [16:0] sum; // sum with carry out
  logic [15:0] sum_w;
  logic cout;
  logic sa;
  logic sd;
  logic sr_sign;
  wire logic is_add = (op == CPUSR_OP_ADD) || (op == CPUSR_OP_ADDC);
  wire logic is_sub = (op == CPUSR_OP_SUB) || (op == CPUSR_OP_SUBC) ||
                      (op == CPUSR_OP_CMP);
  wire logic cin = (op == CPUSR_OP_ADDC || op == CPUSR_OP_SUBC) ?
                   carry_in : (op == CPUSR_OP_SUB || op == CPUSR_OP_CMP);
  wire logic [15:0] b_in = is_sub ? ~src_val : src_val;

  // adder, subtraction as dst + ~src + 1
  always_comb begin
    sum = {1'b0, dst_val} + {1'b0, b_in} + {16'h0000, cin};
    sum_w = is_add || is_sub ? sum[15:0] : src_val;
    if (byte_op) begin
      cout = sum_w[8] ^ dst_val[8] ^ b_in[8];
      sa = src_val[7];
      sd = dst_val[7];
      sr_sign = sum_w[7];
    end else begin
      cout = sum[16];
      sa = src_val[15];
      sd = dst_val[15];
      sr_sign = sum_w[15];
    end
  end

  // byte results clear the upper byte
  assign result = byte_op ? {8'h00, sum_w[7:0]} : sum_w; // RQ17
  assign flag_v = is_add ? ((sa == sd) && (sr_sign != sd)) : // RQ3
                  is_sub ? ((sa != sd) && (sr_sign != sd)) : // RQ4
                  1'b0;
  assign flag_n = sr_sign; // RQ10
  assign flag_z = byte_op ? (sum_w[7:0] == 8'h00) :
                  (sum_w == 16'h0000); // RQ11
  assign flag_c = (is_add || is_sub) ? cout : 1'b0; // RQ12
endmodule

// [rtl/cpusr_regfile.sv]
// cpu register file: sixteen 16-bit registers, status register, constant
// generators and operand mode decoding
// assumes the sequencer drives reads, writes and flag updates on ref_clk
`timescale 1ns/10ps
// Behaviour
// RQ1 - sixteen 16-bit registers, four dedicated
// RQ2 - status operand only in word register mode
// RQ3 - add overflow on same-sign inputs, sign flip
// RQ4 - subtract overflow on mixed signs, sign flip
// RQ5 - second clock bit stops sub-main clock
// RQ6 - first bit stops oscillator dc generator if unused
// RQ7 - oscillator-off stops crystal when its clock unused
// RQ8 - processor-off bit halts processor
// RQ9 - global enable gates maskable interrupts
// RQ10 - negative flag takes result top bit
// RQ11 - zero flag set on zero result
// RQ12 - carry flag follows carry out
// RQ13 - status source modes give zero, four, eight
// RQ14 - register three gives 0,1,2,all-ones, no fetch
// RQ15 - constant registers are source-only, writes dropped
// RQ16 - general registers usable byte or word
// RQ17 - byte write clears upper byte, byte flags
// RQ18 - seven source, four destination modes decoded
// RQ19 - indexed: register plus next-word offset
// RQ20 - symbolic is indexed on program counter
// RQ21 - absolute is indexed on status, base zero; src_operand carries status_r instead
// RQ22 - source indirect uses register as pointer
// RQ23 - autoincrement steps by one or two
// RQ24 - immediate is autoincrement on program counter
module cpusr_regfile
  import cpusr_pkg::*;
#(
  parameter int W = DATA_W
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  // operand decode request
  input wire logic [3:0] src_reg,
  input wire logic [1:0] source_mode_field,
  input wire logic [3:0] dst_reg,
  input wire logic dst_mode,
  input wire logic byte_op,
  // register read, one cycle later on the outputs
  input wire logic [3:0] rd_addr_b,
  // alu execute strobe
  input wire logic exec_valid,
  input cpusr_op_t exec_op,
  input wire logic [W-1:0] exec_src,
  input wire logic [W-1:0] exec_dst,
  input wire logic exec_wr,
  input wire logic exec_flags,
  // direct register write from the sequencer (loads, pointer updates)
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic wr_byte,
  // autoincrement strobe for the source register
  input wire logic inc_en,
  // oscillator usage and interrupt request from the clock system
  input wire logic dco_in_use,
  input wire logic lfxt_in_use,
  input wire logic irq_pending,
  // outputs, all registered
  output logic [W-1:0] src_operand,
  output logic [W-1:0] rd_data_b,
  output cpusr_acc_t src_acc,
  output cpusr_acc_t dst_acc,
  output logic src_ext_word,
  output logic dst_ext_word,
  output logic [W-1:0] exec_result,
  output logic [W-1:0] cpu_status_flags,
  output logic sub_main_clock_off,
  output logic dco_dc_off,
  output logic lowfreq_crystal_stop,
  output logic processor_halt,
  output logic irq_take
);
  logic [W-1:0] regs_r [REG_CNT]; // register array, r0..r15
  logic [W-1:0] status_r; // status register contents
  logic [W-1:0] status_nxt;
  logic [W-1:0] src_op_r;
  logic [W-1:0] rd_b_r;
  cpusr_acc_t src_acc_r;
  cpusr_acc_t dst_acc_r;
  logic src_ext_r;
  logic dst_ext_r;
  logic [W-1:0] result_r;
  logic sub_main_clock_off_r;
  logic dco_off_r;
  logic lfxt_off_r;
  logic halt_r;
  logic irq_r;

  // decoder outputs
  cpusr_acc_t dec_src_acc;
  cpusr_acc_t dec_dst_acc;
  logic [W-1:0] dec_const;
  logic dec_src_ext;
  logic dec_dst_ext;
  logic [W-1:0] dec_inc;

  // flag unit outputs
  logic [W-1:0] alu_res;
  logic alu_v;
  logic alu_n;
  logic alu_z;
  logic alu_c;

  cpusr_mode_dec u_dec (
    .src_reg(src_reg),
    .source_mode_field(source_mode_field),
    .byte_op(byte_op),
    .dst_reg(dst_reg),
    .dst_mode(dst_mode),
    .src_acc(dec_src_acc),
    .dst_acc(dec_dst_acc),
    .const_val(dec_const),
    .src_ext_word(dec_src_ext),
    .dst_ext_word(dec_dst_ext),
    .src_inc(dec_inc)
  );

  cpusr_flag_calc u_flags (
    .op(exec_op),
    .byte_op(byte_op),
    .src_val(exec_src),
    .dst_val(exec_dst),
    .carry_in(status_r[BIT_C]),
    .result(alu_res),
    .flag_v(alu_v),
    .flag_n(alu_n),
    .flag_z(alu_z),
    .flag_c(alu_c)
  );

  // a write target that stores: never r3, which acts only as a constant
  function automatic logic stores(input logic [3:0] a);
    stores = (a != REG_CONST); // RQ15
  endfunction

  // byte writes keep only the low byte, upper byte reads zero
  function automatic logic [15:0] size_data(input logic [15:0] d,
                                            input logic b);
    size_data = b ? {8'h00, d[7:0]} : d; // RQ17 RQ16
  endfunction

  // execute writes back to the destination register
  wire logic exec_store = exec_valid && exec_wr && !dst_mode &&
                          stores(dst_reg);
  wire logic [W-1:0] exec_data = size_data(alu_res, byte_op);
  wire logic direct_store = wr_en && stores(wr_addr);
  wire logic [W-1:0] direct_data = size_data(wr_data, wr_byte);
  // autoincrement only for mode 11 on a real register
  wire logic inc_store = inc_en &&
                         (dec_src_acc == CPUSR_ACC_AUTOINC ||
                          dec_src_acc == CPUSR_ACC_IMMEDIATE);
  // source operand: generated constant or register contents
  wire logic [W-1:0] src_value = (dec_src_acc == CPUSR_ACC_CONST) ?
                                 dec_const : // RQ13 RQ14
                                 (src_reg == REG_STATUS) ? status_r :
                                 regs_r[src_reg]; // RQ2
  wire logic [W-1:0] rd_b_value = (rd_addr_b == REG_STATUS) ? status_r :
                                  (rd_addr_b == REG_CONST) ? CONST_ZERO :
                                  regs_r[rd_addr_b];

  // status next value: direct writes, then an execute write to status or else flag updates win over them
  always_comb begin
    status_nxt = status_r;
    if (direct_store && wr_addr == REG_STATUS && !wr_byte) begin
      status_nxt = wr_data & STATUS_MASK; // RQ2
    end
    if (exec_store && dst_reg == REG_STATUS && !byte_op) begin
      status_nxt = alu_res & STATUS_MASK; // RQ2
    end else if (exec_valid && exec_flags) begin
      status_nxt[BIT_V] = alu_v; // RQ3 RQ4
      status_nxt[BIT_N] = alu_n; // RQ10
      status_nxt[BIT_Z] = alu_z; // RQ11
      status_nxt[BIT_C] = alu_c; // RQ12
    end
  end

  // general registers r0, r1 and r4..r15 (r2, r3 handled apart)
  genvar gi;
  generate
    for (gi = 0; gi < REG_CNT; gi++) begin : g_reg // RQ1
      if (gi == 2 || gi == 3) begin : g_none
        always_ff @(posedge ref_clk or negedge rst_n) begin
          if (!rst_n) begin
            regs_r[gi] <= REG_RST;
          end else begin
            regs_r[gi] <= REG_RST; // RQ15
          end
        end
      end else begin : g_gpr
        always_ff @(posedge ref_clk or negedge rst_n) begin
          if (!rst_n) begin
            regs_r[gi] <= REG_RST;
          end else if (exec_store && dst_reg == 4'(gi)) begin
            regs_r[gi] <= exec_data; // RQ16
          end else if (direct_store && wr_addr == 4'(gi)) begin
            regs_r[gi] <= direct_data; // RQ16
          end else if (inc_store && src_reg == 4'(gi)) begin
            regs_r[gi] <= regs_r[gi] + dec_inc; // RQ23 RQ24
          end
        end
      end
    end
  endgenerate

  // status register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // decode and read results registered for the sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_op_r <= REG_RST;
      rd_b_r <= REG_RST;
      src_acc_r <= CPUSR_ACC_REG;
      dst_acc_r <= CPUSR_ACC_REG;
      src_ext_r <= 1'b0;
      dst_ext_r <= 1'b0;
      result_r <= REG_RST;
    end else begin
      src_op_r <= src_value;
      rd_b_r <= rd_b_value;
      src_acc_r <= dec_src_acc; // RQ18 RQ22
      dst_acc_r <= dec_dst_acc; // RQ18
      src_ext_r <= dec_src_ext; // RQ19 RQ21
      dst_ext_r <= dec_dst_ext;
      result_r <= exec_valid ? exec_data : result_r;
    end
  end

  // low-power controls and interrupt gate from the new status bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_main_clock_off_r <= 1'b0;
      dco_off_r <= 1'b0;
      lfxt_off_r <= 1'b0;
      halt_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      sub_main_clock_off_r <= status_nxt[BIT_CG1]; // RQ5
      dco_off_r <= status_nxt[BIT_CG0] && !dco_in_use; // RQ6
      lfxt_off_r <= status_nxt[BIT_LOWFREQ_CRYSTAL_STOP] && !lfxt_in_use; // RQ7
      halt_r <= status_nxt[BIT_HALT]; // RQ8
      irq_r <= irq_pending && status_nxt[BIT_GIE]; // RQ9
    end
  end

  assign src_operand = src_op_r;
  assign rd_data_b = rd_b_r;
  assign src_acc = src_acc_r;
  assign dst_acc = dst_acc_r;
  assign src_ext_word = src_ext_r;
  assign dst_ext_word = dst_ext_r;
  assign exec_result = result_r;
  assign cpu_status_flags = status_r;
  assign sub_main_clock_off = sub_main_clock_off_r;
  assign dco_dc_off = dco_off_r;
  assign lowfreq_crystal_stop = lfxt_off_r;
  assign processor_halt = halt_r;
  assign irq_take = irq_r;
endmodule

// [verif/cpusr_regfile_sva.sv]
// checker for the cpu register side ports
// assumes one clock, ref_clk, with async active-low rst_n
`timescale 1ns/10ps
module cpusr_regfile_sva
  import cpusr_pkg::*;
#(
  parameter int W = DATA_W
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] src_reg,
  input wire logic [1:0] source_mode_field,
  input wire logic [3:0] dst_reg,
  input wire logic dst_mode,
  input wire logic byte_op,
  input wire logic exec_valid,
  input cpusr_op_t exec_op,
  input wire logic [W-1:0] exec_src,
  input wire logic [W-1:0] exec_dst,
  input wire logic exec_wr,
  input wire logic exec_flags,
  input wire logic dco_in_use,
  input wire logic irq_pending,
  input wire logic [W-1:0] src_operand,
  input cpusr_acc_t src_acc,
  input cpusr_acc_t dst_acc,
  input wire logic src_ext_word,
  input wire logic dst_ext_word,
  input wire logic [W-1:0] exec_result,
  input wire logic [W-1:0] cpu_status_flags,
  input wire logic sub_main_clock_off,
  input wire logic dco_dc_off,
  input wire logic irq_take
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // flag update not overridden by a result written to status
  wire logic flag_upd = exec_valid && exec_flags &&
    !(exec_wr && !dst_mode && dst_reg == REG_STATUS);
  // word add class and word sub/subc class, compare left out
  wire logic add_w = flag_upd && !byte_op &&
    (exec_op == CPUSR_OP_ADD || exec_op == CPUSR_OP_ADDC);
  wire logic sub_w = flag_upd && !byte_op &&
    (exec_op == CPUSR_OP_SUB || exec_op == CPUSR_OP_SUBC);
  // compare is kept out of result checks, though exec_result still takes its difference
  wire logic res_upd = flag_upd && exec_op != CPUSR_OP_CMP;

  property p_v_add;
    add_w |=> cpu_status_flags[BIT_V] == ($past(exec_src[15]) ==
      $past(exec_dst[15]) && exec_result[15] != $past(exec_src[15]));
  endproperty
  a_v_add: assert property (p_v_add) else $error("add overflow wrong");
  property p_v_sub;
    sub_w |=> cpu_status_flags[BIT_V] == ($past(exec_src[15]) !=
      $past(exec_dst[15]) && exec_result[15] != $past(exec_dst[15]));
  endproperty
  a_v_sub: assert property (p_v_sub) else $error("sub overflow wrong");
  property p_nz_w;
    res_upd && !byte_op |=> cpu_status_flags[BIT_N] == exec_result[15] &&
      cpu_status_flags[BIT_Z] == (exec_result == 16'h0000);
  endproperty
  a_nz_w: assert property (p_nz_w) else $error("word n or z wrong");
  property p_nz_b;
    res_upd && byte_op |=> exec_result[15:8] == 8'h00 &&
      cpu_status_flags[BIT_N] == exec_result[7] &&
      cpu_status_flags[BIT_Z] == (exec_result[7:0] == 8'h00);
  endproperty
  a_nz_b: assert property (p_nz_b) else $error("byte result wrong");
  property p_r3_ones;
    src_reg == REG_CONST && source_mode_field == AS_INC |=>
      src_operand == CONST_ONES && src_acc == CPUSR_ACC_CONST && !src_ext_word;
  endproperty
  a_r3_ones: assert property (p_r3_ones) else $error("r3 const wrong");
  property p_r2_eight;
    src_reg == REG_STATUS && source_mode_field == AS_INC |=>
      src_operand == CONST_EIGHT && !src_ext_word;
  endproperty
  a_r2_eight: assert property (p_r2_eight) else $error("r2 const wrong");
  property p_sym;
    dst_reg == REG_PC && dst_mode |=>
      dst_acc == CPUSR_ACC_SYMBOLIC && dst_ext_word;
  endproperty
  a_sym: assert property (p_sym) else $error("symbolic dest wrong");
  property p_sub_main_clock;
    $stable(cpu_status_flags) |->
      sub_main_clock_off == cpu_status_flags[BIT_CG1];
  endproperty
  a_sub_main_clock: assert property (p_sub_main_clock) else $error("sub clock off wrong");
  property p_dco;
    $stable(cpu_status_flags) && $stable(dco_in_use) |->
      dco_dc_off == (cpu_status_flags[BIT_CG0] && !dco_in_use);
  endproperty
  a_dco: assert property (p_dco) else $error("dc generator off wrong");
  property p_irq;
    $stable(cpu_status_flags) && $stable(irq_pending) |->
      irq_take == (cpu_status_flags[BIT_GIE] && irq_pending);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt gate wrong");
  // main scenarios reached
  c_byte: cover property (res_upd && byte_op);
  c_const: cover property (src_reg == REG_CONST && source_mode_field == AS_INC);
  c_irq: cover property (irq_take);
endmodule

// checker ports share the names of the block's ports
bind cpusr_regfile cpusr_regfile_sva #(.W(W)) u_sva (.*);

// [verif/cpusr_clk_sys_model.sv]
// clock-system and interrupt-source model facing the register side
// assumes the bench selects oscillator usage; levels move on ref_clk
`timescale 1ns/10ps
module cpusr_clk_sys_model (
  input wire logic ref_clk,
  input wire logic [2:0] use_cfg,
  output logic dco_in_use = 1'b0,
  output logic lfxt_in_use = 1'b0,
  output logic irq_pending = 1'b0
);
  // levels follow the request one cycle later, like a synchronised source
  always @(posedge ref_clk) begin
    dco_in_use <= use_cfg[0];
    lfxt_in_use <= use_cfg[1];
    irq_pending <= use_cfg[2];
  end
endmodule

// [verif/test_cpusr_regfile.sv]
// self-checking bench: decode, constants, writes, flags, power controls
// assumes the clock-system model and the bound checker alongside
`timescale 1ns/10ps
module test_cpusr_regfile;
  import cpusr_pkg::*;
  // short names for the access kinds in the decode table
  localparam cpusr_acc_t A_RG = CPUSR_ACC_REG;
  localparam cpusr_acc_t A_IX = CPUSR_ACC_INDEXED;
  localparam cpusr_acc_t A_SY = CPUSR_ACC_SYMBOLIC;
  localparam cpusr_acc_t A_AB = CPUSR_ACC_ABSOLUTE;
  localparam cpusr_acc_t A_IN = CPUSR_ACC_INDIRECT;
  localparam cpusr_acc_t A_AI = CPUSR_ACC_AUTOINC;
  localparam cpusr_acc_t A_IM = CPUSR_ACC_IMMEDIATE;
  localparam cpusr_acc_t A_CO = CPUSR_ACC_CONST;
  // stimulus, each given a value at time zero
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] src_reg = 4'h0, dst_reg = 4'h0;
  logic [3:0] rd_addr_b = 4'h0, wr_addr = 4'h0;
  logic [1:0] source_mode_field = 2'h0;
  logic dst_mode = 1'b0, byte_op = 1'b0, exec_valid = 1'b0;
  logic exec_wr = 1'b0, exec_flags = 1'b0, wr_en = 1'b0;
  logic wr_byte = 1'b0, inc_en = 1'b0;
  cpusr_op_t exec_op = CPUSR_OP_MOV;
  logic [15:0] exec_src = 16'h0000, exec_dst = 16'h0000;
  logic [15:0] wr_data = 16'h0000;
  logic [2:0] use_cfg = 3'h0;
  // observed levels and outputs
  logic dco_in_use, lfxt_in_use, irq_pending;
  logic [15:0] src_operand, rd_data_b, exec_result, cpu_status_flags;
  cpusr_acc_t src_acc, dst_acc;
  logic src_ext_word, dst_ext_word, sub_main_clock_off, dco_dc_off;
  logic lowfreq_crystal_stop, processor_halt, irq_take;
  // power and interrupt controls gathered into one word
  wire logic [15:0] ctl = {11'h0, sub_main_clock_off, dco_dc_off,
    lowfreq_crystal_stop, processor_halt, irq_take};
  int num_errors = 0;
  int n_compared = 0;

  // free-running clock
  always #2 ref_clk = ~ref_clk;

  // every bench signal carries the name of the port it meets
  cpusr_clk_sys_model u_clk (.*);
  cpusr_regfile dut (.*);

  // compare a word result
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  // compare an access kind
  task automatic chk_acc(input cpusr_acc_t got, input cpusr_acc_t exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t access %0d expected %0d", $time, got, exp);
    end
  endtask
  // direct register write, one cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d,
      input logic b);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    wr_byte <= b;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  // second read port, data one cycle after the address
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    rd_addr_b <= a;
    @(posedge ref_clk);
    #1 chk_word(rd_data_b, exp);
  endtask
  // operand decode; destination mode follows the low source mode bit
  task automatic dec(input logic [3:0] r, input logic [1:0] m,
      input logic [3:0] d, input cpusr_acc_t sa, input cpusr_acc_t da,
      input logic [1:0] ext, input logic [15:0] v);
    @(posedge ref_clk);
    src_reg <= r;
    source_mode_field <= m;
    dst_reg <= d;
    dst_mode <= m[0];
    @(posedge ref_clk);
    #1 chk_acc(src_acc, sa);
    chk_acc(dst_acc, da);
    chk_word({14'h0, src_ext_word, dst_ext_word}, {14'h0, ext});
    chk_word(src_operand, v);
  endtask
  // post-increment: decode settles a cycle before the strobe
  task automatic inc(input logic [3:0] r, input logic b);
    @(posedge ref_clk);
    src_reg <= r;
    source_mode_field <= AS_INC;
    byte_op <= b;
    @(posedge ref_clk);
    inc_en <= 1'b1;
    @(posedge ref_clk);
    inc_en <= 1'b0;
  endtask
  // set oscillator usage and interrupt request, then check the controls
  task automatic ctl_chk(input logic [2:0] c, input logic [15:0] exp);
    @(posedge ref_clk);
    use_cfg <= c;
    repeat (3) @(posedge ref_clk);
    #1 chk_word(ctl, exp);
  endtask
  // execute with flag update, no result write
  task automatic ex(input cpusr_op_t op, input logic b, input logic [15:0] s,
      input logic [15:0] d, input logic [15:0] res, input logic [15:0] st);
    @(posedge ref_clk);
    exec_valid <= 1'b1;
    exec_op <= op;
    byte_op <= b;
    exec_src <= s;
    exec_dst <= d;
    exec_flags <= 1'b1;
    @(posedge ref_clk);
    exec_valid <= 1'b0;
    #1 chk_word(exec_result, res);
    chk_word(cpu_status_flags, st);
  endtask
  // counts, verdict, end of run
  task automatic end_of_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk_word(cpu_status_flags, STATUS_RST);
    chk_word(ctl, 16'h0000);
    wr(4'h5, 16'h1234, 1'b0);
    dec(4'h5, 2'h0, 4'h5, A_RG, A_RG, 2'b00, 16'h1234);
    dec(4'h5, 2'h1, 4'h5, A_IX, A_IX, 2'b11, 16'h1234);
    dec(4'h5, 2'h2, 4'h2, A_IN, A_RG, 2'b00, 16'h1234);
    dec(4'h5, 2'h3, 4'h0, A_AI, A_SY, 2'b01, 16'h1234);
    dec(4'h0, 2'h3, 4'h2, A_IM, A_AB, 2'b11, 16'h0000);
    dec(4'h0, 2'h1, 4'h0, A_SY, A_SY, 2'b11, 16'h0000);
    dec(4'h2, 2'h0, 4'h5, A_RG, A_RG, 2'b00, 16'h0000);
    dec(4'h2, 2'h1, 4'h5, A_AB, A_IX, 2'b11, CONST_ZERO);
    dec(4'h2, 2'h2, 4'h5, A_CO, A_RG, 2'b00, CONST_FOUR);
    dec(4'h2, 2'h3, 4'h5, A_CO, A_IX, 2'b01, CONST_EIGHT);
    dec(4'h3, 2'h0, 4'h5, A_CO, A_RG, 2'b00, CONST_ZERO);
    dec(4'h3, 2'h1, 4'h5, A_CO, A_IX, 2'b01, CONST_ONE);
    dec(4'h3, 2'h2, 4'h5, A_CO, A_RG, 2'b00, CONST_TWO);
    dec(4'h3, 2'h3, 4'h5, A_CO, A_IX, 2'b01, CONST_ONES);
    wr(4'h6, 16'habcd, 1'b1);
    rd(4'h6, 16'h00cd);
    wr(4'h3, 16'h5a5a, 1'b0);
    rd(4'h3, 16'h0000);
    wr(4'h2, 16'h00ff, 1'b1);
    rd(4'h2, 16'h0000);
    wr(4'h2, 16'h00f8, 1'b0);
    rd(4'h2, 16'h00f8);
    ctl_chk(3'b101, 16'h0017);
    ctl_chk(3'b010, 16'h001a);
    wr(4'h2, 16'h0008, 1'b0);
    ctl_chk(3'b100, 16'h0001);
    wr(4'h2, 16'h0000, 1'b0);
    ctl_chk(3'b100, 16'h0000);
    inc(4'h5, 1'b1);
    rd(4'h5, 16'h1235);
    inc(4'h5, 1'b0);
    rd(4'h5, 16'h1237);
    ex(CPUSR_OP_ADD, 1'b0, 16'h0001, 16'h7fff, 16'h8000, 16'h0104);
    ex(CPUSR_OP_ADD, 1'b0, 16'h0001, 16'hffff, 16'h0000, 16'h0003);
    ex(CPUSR_OP_ADDC, 1'b0, 16'h0001, 16'h0001, 16'h0003, 16'h0000);
    ex(CPUSR_OP_SUB, 1'b0, 16'h0001, 16'h8000, 16'h7fff, 16'h0101);
    ex(CPUSR_OP_SUBC, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0003);
    ex(CPUSR_OP_CMP, 1'b0, 16'h8000, 16'h0000, 16'h8000, 16'h0104);
    ex(CPUSR_OP_ADD, 1'b1, 16'h127f, 16'hab01, 16'h0080, 16'h0104);
    ex(CPUSR_OP_SUB, 1'b1, 16'h0001, 16'h0000, 16'h00ff, 16'h0004);
    end_of_test();
  end
endmodule
